// *** pkg/bcc_pkg.sv ***
// shared constants for the binary correlator core
package bcc_pkg;
    localparam int STAGES = 8;                 // number of internal tap stages
    localparam int TAPS = 32;                  // taps per stage
    localparam int REF_BITS = 256;             // reference and mask length
    localparam int SCORE_W = 13;               // score and cascade width
    localparam int CNT_W = 6;                  // per-stage match count width
    localparam int DATA_W = 8;                 // sample input width
    localparam int BUS_W = 8;                  // write bus width
    localparam int ADDR_W = 3;                 // control address width
    localparam int DELAY_W = 4;                // programmable delay field width
    localparam int DELAY_DEPTH = 16;           // delay line entries
    // control register addresses
    localparam logic [2:0] ADDR_CONFIG = 3'h0;
    localparam logic [2:0] ADDR_OFFSET_LO = 3'h1;
    localparam logic [2:0] ADDR_OFFSET_HI = 3'h2;
    localparam logic [2:0] ADDR_DELAY = 3'h3;
    // config field positions
    localparam int CFG_WIDTH_LSB = 0;          // two bits: 0=1b 1=2b 2=4b 3=8b
    localparam int CFG_SPLIT_BIT = 2;          // two independent correlators
    localparam int CFG_WIN128_BIT = 3;         // split window 1x128 (else 4x32)
    localparam int CFG_TARGET_BIT = 4;         // reference writes go to mask
    localparam int OFFSET_HI_W = 5;            // upper offset bits held at address 2
    // reset values
    localparam logic [7:0] CONFIG_RST = 8'h00;
    localparam logic [12:0] OFFSET_RST = 13'h0000;
    localparam logic [3:0] DELAY_RST = 4'h0;
    localparam logic [255:0] REF_RST = 256'h0;
    localparam logic [255:0] MASK_RST = 256'h0;
endpackage

// *** rtl/bcc_core.sv ***
// binary correlator core: tap array, weighting, offset, delay and cascade summer
// Contract
// [R1] 256 taps in eight chainable 32-tap stages
// [R2] 1/2/4/8-bit samples against 1-bit reference
// [R3] split mode: two correlators, 4x32 or 1x128
// [R4] 256-bit mask removes chosen taps from score
// [R5] weight and sum partial scores by format
// [R6] add offset register to weighted score
// [R7] programmable delay before cascade summer
// [R8] add own score to incoming cascade value
// [R9] control, reference and mask double buffered
// [R10] host writes control via address and data
// [R11] separate control and reference write ports
// [R12] commit strobe transfers shadow data on clock
// [R13] host load strobes asynchronous active-low pulses
// [R14] host waits one clock before commit strobe
// [R15] outputs registered; one sample per clock
`timescale 1ns/1ps
module bcc_core (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] data_in,
    input wire logic [7:0] ref_write_bus,
    input wire logic ref_write_strobe_n,
    input wire logic [7:0] ctrl_write_bus,
    input wire logic [2:0] ctrl_addr,
    input wire logic ctrl_write_strobe_n,
    input wire logic commit_strobe_n,
    input wire logic [12:0] chain_sum_in,
    output logic [12:0] chain_sum_out,
    output logic [12:0] side_score_out
);
    // pin synchronisers: first stage feeds only the second
    logic [7:0] din_m, din_s;               // sample data
    logic [7:0] rbus_m, rbus_s;             // reference write data
    logic [7:0] cbus_m, cbus_s;             // control write data
    logic [2:0] addr_m, addr_s;             // control address
    logic rstb_m, rstb_s, rstb_d;           // reference strobe and delayed copy
    logic cstb_m, cstb_s, cstb_d;           // control strobe and delayed copy
    logic cmt_m, cmt_s;                     // commit strobe
    logic [12:0] cin_m, cin_s;              // cascade input
    logic ref_load, ctrl_load, commit;      // one-cycle load events; commit is a level held while the strobe is low

    // two-flop capture of the data, bus, address and cascade pin inputs
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            din_m <= 8'h00;
            din_s <= 8'h00;
            rbus_m <= 8'h00;
            rbus_s <= 8'h00;
            cbus_m <= 8'h00;
            cbus_s <= 8'h00;
            addr_m <= 3'h0;
            addr_s <= 3'h0;
            cin_m <= 13'h0000;
            cin_s <= 13'h0000;
        end else begin
            din_m <= data_in;
            din_s <= din_m;
            rbus_m <= ref_write_bus;
            rbus_s <= rbus_m;
            cbus_m <= ctrl_write_bus;
            cbus_s <= cbus_m;
            addr_m <= ctrl_addr;
            addr_s <= addr_m;
            cin_m <= chain_sum_in;
            cin_s <= cin_m;
        end
    end

    // strobe synchronisers; idle level of the active-low strobes is high
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rstb_m <= 1'b1;
            rstb_s <= 1'b1;
            rstb_d <= 1'b1;
            cstb_m <= 1'b1;
            cstb_s <= 1'b1;
            cstb_d <= 1'b1;
            cmt_m <= 1'b1;
            cmt_s <= 1'b1;
        end else begin
            rstb_m <= ref_write_strobe_n;
            rstb_s <= rstb_m;
            rstb_d <= rstb_s;
            cstb_m <= ctrl_write_strobe_n;
            cstb_s <= cstb_m;
            cstb_d <= cstb_s;
            cmt_m <= commit_strobe_n;
            cmt_s <= cmt_m;
        end
    end

    // loads act on the rising (closing) edge of each write pulse
    assign ref_load = rstb_s & ~rstb_d;   // R11 R13
    assign ctrl_load = cstb_s & ~cstb_d;  // R10 R11 R13
    assign commit = ~cmt_s;               // R12

    // shadow and active control state
    logic [7:0] cfg_sh, cfg_act;            // config byte
    logic [12:0] off_sh, off_act;           // score offset
    logic [3:0] dly_sh, dly_act;            // delay length
    logic [255:0] ref_sh, ref_act;          // reference bits
    logic [255:0] mask_sh, mask_act;        // mask bits, one excludes a tap

    // control shadow writes by address
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfg_sh <= bcc_pkg::CONFIG_RST;
            off_sh <= bcc_pkg::OFFSET_RST;
            dly_sh <= bcc_pkg::DELAY_RST;
        end else if (ctrl_load) begin
            unique case (addr_s)
                bcc_pkg::ADDR_CONFIG: begin
                    cfg_sh <= cbus_s; // R10
                end
                bcc_pkg::ADDR_OFFSET_LO: begin
                    off_sh[7:0] <= cbus_s;
                end
                bcc_pkg::ADDR_OFFSET_HI: begin
                    off_sh[12:8] <= cbus_s[bcc_pkg::OFFSET_HI_W-1:0];
                end
                bcc_pkg::ADDR_DELAY: begin
                    dly_sh <= cbus_s[bcc_pkg::DELAY_W-1:0];
                end
                default: begin
                    // unused addresses are ignored
                end
            endcase
        end
    end

    // reference writes shift a byte into reference or mask shadow
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ref_sh <= bcc_pkg::REF_RST;
            mask_sh <= bcc_pkg::MASK_RST;
        end else if (ref_load) begin
            if (cfg_sh[bcc_pkg::CFG_TARGET_BIT]) begin
                mask_sh <= {mask_sh[247:0], rbus_s}; // R4 R11
            end else begin
                ref_sh <= {ref_sh[247:0], rbus_s}; // R11
            end
        end
    end

    // commit moves every shadow into the working set
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfg_act <= bcc_pkg::CONFIG_RST;
            off_act <= bcc_pkg::OFFSET_RST;
            dly_act <= bcc_pkg::DELAY_RST;
            ref_act <= bcc_pkg::REF_RST;
            mask_act <= bcc_pkg::MASK_RST;
        end else if (commit) begin
            cfg_act <= cfg_sh; // R9 R12
            off_act <= off_sh;
            dly_act <= dly_sh;
            ref_act <= ref_sh;
            mask_act <= mask_sh;
        end
    end

    // decoded working mode
    logic split, win128;                    // split mode and its window
    logic [1:0] wsel;                       // sample width code
    logic [3:0] nb;                         // bits per sample
    assign split = cfg_act[bcc_pkg::CFG_SPLIT_BIT];
    assign win128 = cfg_act[bcc_pkg::CFG_WIN128_BIT];
    assign wsel = cfg_act[bcc_pkg::CFG_WIDTH_LSB +: 2];
    assign nb = 4'h1 << wsel; // R2

    // tap array and stage inputs
    logic [7:0][31:0] taps;                 // tap shift registers per stage
    logic [7:0] stage_in;                   // bit entering each stage
    logic [7:0][5:0] cnt;                   // matches per stage

    // stage input: fresh sample bit or the tail of an earlier stage
    always_comb begin
        stage_in = 8'h00;
        for (int k = 0; k < bcc_pkg::STAGES; k++) begin
            if (split) begin
                if (win128 && k != 0 && k != 4) begin
                    stage_in[k] = taps[k-1][31]; // R3
                end else begin
                    stage_in[k] = din_s[k]; // R3
                end
            end else if (k < int'(nb)) begin
                stage_in[k] = din_s[k]; // R2
            end else begin
                stage_in[k] = taps[k-int'(nb)][31]; // R1
            end
        end
    end

    // per-stage shift and match count
    generate
        for (genvar g = 0; g < bcc_pkg::STAGES; g++) begin : g_stage
            // one sample step per clock
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    taps[g] <= 32'h0;
                end else begin
                    taps[g] <= {taps[g][30:0], stage_in[g]}; // R15
                end
            end
            // count agreeing, unmasked taps
            always_comb begin
                logic [31:0] hit;
                hit = ~(taps[g] ^ ref_act[g*32 +: 32]) & ~mask_act[g*32 +: 32]; // R4
                cnt[g] = 6'h00;
                for (int t = 0; t < bcc_pkg::TAPS; t++) begin
                    cnt[g] = cnt[g] + {5'h00, hit[t]};
                end
            end
        end
    endgenerate

    // weighting and summing of partial scores
    logic [12:0] next_sum_a, next_sum_b, next_total;
    always_comb begin
        logic [3:0] w;
        w = 4'h0;
        next_sum_a = 13'h0000;
        next_sum_b = 13'h0000;
        next_total = 13'h0000;
        for (int k = 0; k < bcc_pkg::STAGES; k++) begin
            w = split ? 4'h0 : (4'(k) & (nb - 4'h1)); // R5
            next_total = next_total + 13'({7'h00, cnt[k]} << w);
            if (k < 4) begin
                next_sum_a = next_sum_a + {7'h00, cnt[k]};
            end else begin
                next_sum_b = next_sum_b + {7'h00, cnt[k]};
            end
        end
    end

    // registered score, offset and delay pipeline
    logic [12:0] score, side_score, off_score, delayed;
    logic [12:0] dline [16];                // delay line entries

    // main score and split second score
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            score <= 13'h0000;
            side_score <= 13'h0000;
        end else begin
            score <= split ? next_sum_a : next_total; // R3 R5
            side_score <= split ? next_sum_b : next_total;
        end
    end

    // offset addition
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            off_score <= 13'h0000;
        end else begin
            off_score <= score + off_act; // R6
        end
    end

    // delay line shifts every clock; tap chosen by delay length
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < bcc_pkg::DELAY_DEPTH; i++) begin
                dline[i] <= 13'h0000;
            end
        end else begin
            dline[0] <= off_score;
            for (int i = 1; i < bcc_pkg::DELAY_DEPTH; i++) begin
                dline[i] <= dline[i-1];
            end
        end
    end
    // length 0 passes the offset score straight on
    assign delayed = (dly_act == 4'h0) ? off_score : dline[dly_act - 4'h1]; // R7

    // cascade summer and registered outputs
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            chain_sum_out <= 13'h0000;
            side_score_out <= 13'h0000;
        end else begin
            chain_sum_out <= delayed + cin_s; // R8 R15
            side_score_out <= side_score; // R15
        end
    end

    // commit copies shadow reference and mask
    a_commit_copy: assert property (@(posedge clock) disable iff (rst)
        commit |=> (ref_act == $past(ref_sh)) && (mask_act == $past(mask_sh))) // R12
        else $error("commit did not transfer shadow data");

    // working reference and config hold between commits
    a_active_hold: assert property (@(posedge clock) disable iff (rst)
        !commit |=> $stable(ref_act) && $stable(cfg_act)) // R9
        else $error("working set changed without commit");

    // reference byte enters the low end of the shadow
    a_ref_shift_in: assert property (@(posedge clock) disable iff (rst)
        ref_load && !cfg_sh[bcc_pkg::CFG_TARGET_BIT] |=> ref_sh[7:0] == $past(rbus_s)) // R11
        else $error("reference byte not loaded");

    // delay register follows a control write
    a_delay_write: assert property (@(posedge clock) disable iff (rst)
        ctrl_load && addr_s == bcc_pkg::ADDR_DELAY |=> dly_sh == $past(cbus_s[3:0])) // R10
        else $error("delay field not written");

    // full mask forces zero score
    a_mask_blocks: assert property (@(posedge clock) disable iff (rst)
        (&mask_act) && !split |=> score == 13'h0000) // R4
        else $error("masked taps contributed to score");

    // offset is added one cycle after the score
    a_offset_sum: assert property (@(posedge clock) disable iff (rst)
        1'b1 |=> off_score == 13'($past(score) + $past(off_act))) // R6
        else $error("offset sum wrong");

    // zero delay length feeds the summer directly
    a_zero_delay: assert property (@(posedge clock) disable iff (rst)
        dly_act == 4'h0 ##1 dly_act == 4'h0 |-> chain_sum_out == 13'($past(off_score) + $past(cin_s))) // R7
        else $error("zero delay path wrong");

    // cascade output adds own delayed score to the input
    a_chain_add: assert property (@(posedge clock) disable iff (rst)
        1'b1 |=> chain_sum_out == 13'($past(delayed) + $past(cin_s))) // R8
        else $error("cascade sum wrong");

    // first tap takes one new sample bit per clock
    a_sample_step: assert property (@(posedge clock) disable iff (rst)
        1'b1 |=> taps[0][0] == $past(din_s[0]) && taps[0][31:1] == $past(taps[0][30:0])) // R15
        else $error("tap array did not advance");

    // eight-bit mode feeds every stage a fresh bit
    a_wide_inputs: assert property (@(posedge clock) disable iff (rst)
        !split && wsel == 2'h3 |-> stage_in == din_s) // R2
        else $error("eight-bit stage inputs wrong");
endmodule

// *** tb/bcc_host.sv ***
// host model: control and reference write ports with active-low strobes
`timescale 1ns/1ps
module bcc_host (
    input wire logic clock,
    output logic [7:0] ctrl_write_bus,
    output logic [2:0] ctrl_addr,
    output logic ctrl_write_strobe_n,
    output logic [7:0] ref_write_bus,
    output logic ref_write_strobe_n
);
    // idle levels at time zero
    initial begin
        ctrl_write_bus = 8'h00;
        ctrl_addr = 3'h0;
        ctrl_write_strobe_n = 1'b1;
        ref_write_bus = 8'h00;
        ref_write_strobe_n = 1'b1;
    end
    // one control write, address and data held well around the rising strobe
    task automatic ctrl_write(input logic [2:0] addr, input logic [7:0] data);
        @(negedge clock);
        ctrl_addr = addr;
        ctrl_write_bus = data;
        ctrl_write_strobe_n = 1'b0;
        repeat (3) @(negedge clock);
        ctrl_write_strobe_n = 1'b1;
        repeat (3) @(negedge clock);
        // released lines stop showing the written value
        ctrl_addr = ~addr;
        ctrl_write_bus = ~data;
    endtask
    // one reference or mask byte on its own port
    task automatic ref_write(input logic [7:0] data);
        @(negedge clock);
        ref_write_bus = data;
        ref_write_strobe_n = 1'b0;
        repeat (3) @(negedge clock);
        ref_write_strobe_n = 1'b1;
        repeat (3) @(negedge clock);
        ref_write_bus = ~data;
    endtask
endmodule

// *** tb/tb_binary_correlator_core.sv ***
// self-checking bench for the correlator core
`timescale 1ns/1ps
module tb_binary_correlator_core;
    logic clock;
    logic rst;
    logic [7:0] data_in;
    logic commit_strobe_n;
    logic [12:0] chain_sum_in;
    logic [12:0] chain_sum_out;
    logic [12:0] side_score_out;
    logic [7:0] ctrl_write_bus;
    logic [2:0] ctrl_addr;
    logic ctrl_write_strobe_n;
    logic [7:0] ref_write_bus;
    logic ref_write_strobe_n;
    int n_mismatch = 0; // failed comparisons
    int checked = 0; // comparisons made
    int cycles = 0; // timeout counter
    int n0;
    int n5;
    // device under test
    bcc_core u_dut (.clock(clock), .rst(rst), .data_in(data_in), .ref_write_bus(ref_write_bus),
        .ref_write_strobe_n(ref_write_strobe_n), .ctrl_write_bus(ctrl_write_bus), .ctrl_addr(ctrl_addr),
        .ctrl_write_strobe_n(ctrl_write_strobe_n), .commit_strobe_n(commit_strobe_n),
        .chain_sum_in(chain_sum_in), .chain_sum_out(chain_sum_out), .side_score_out(side_score_out));
    // host partner on the write ports
    bcc_host u_host (.clock(clock), .ctrl_write_bus(ctrl_write_bus), .ctrl_addr(ctrl_addr),
        .ctrl_write_strobe_n(ctrl_write_strobe_n), .ref_write_bus(ref_write_bus),
        .ref_write_strobe_n(ref_write_strobe_n));
    // 40 MHz clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end
    // verdict and end of run
    task automatic stop_test();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // compare one 13-bit result
    task automatic chk13(input logic [12:0] got, input logic [12:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // wait whole cycles, ending on a falling edge
    task automatic settle(input int n);
        repeat (n) @(negedge clock);
    endtask
    // one low cycle of the commit strobe after loads have settled
    task automatic commit();
        settle(4);
        commit_strobe_n = 1'b0;
        @(negedge clock);
        commit_strobe_n = 1'b1;
    endtask
    // load 32 mask bytes then 32 reference bytes, then the final config
    task automatic load(input logic [7:0] cfg, input logic [7:0] mbyte, input logic [7:0] rbyte);
        u_host.ctrl_write(bcc_pkg::ADDR_CONFIG, 8'h10);
        repeat (32) u_host.ref_write(mbyte);
        u_host.ctrl_write(bcc_pkg::ADDR_CONFIG, 8'h00);
        repeat (32) u_host.ref_write(rbyte);
        u_host.ctrl_write(bcc_pkg::ADDR_CONFIG, cfg);
    endtask
    // commit and count cycles until the cascade output moves
    task automatic latency(output int n);
        logic [12:0] prev;
        prev = chain_sum_out;
        commit();
        n = 0;
        while (chain_sum_out === prev && n < 60) begin
            @(negedge clock);
            n++;
        end
    endtask
    // all 256 taps match zero data against zero reference
    task automatic t_plain();
        settle(300);
        chk13(chain_sum_out, 13'h100, "full length score");
        chk13(side_score_out, 13'h100, "side score");
        $display("test plain done");
    endtask
    // shadow mask waits for commit, then removes every tap; cascade adds in
    task automatic t_mask();
        load(8'h00, 8'hff, 8'h00);
        settle(10);
        chk13(chain_sum_out, 13'h100, "score before commit");
        commit();
        settle(10);
        chk13(chain_sum_out, 13'h000, "masked score");
        chk13(side_score_out, 13'h000, "masked side");
        chain_sum_in = 13'h005;
        settle(6);
        chk13(chain_sum_out, 13'h005, "cascade pass");
        chain_sum_in = 13'h000;
        settle(6);
        $display("test mask done");
    endtask
    // offset reaches the cascade output only, delay adds its length
    task automatic t_offset_delay();
        u_host.ctrl_write(bcc_pkg::ADDR_OFFSET_LO, 8'h10);
        u_host.ctrl_write(bcc_pkg::ADDR_OFFSET_HI, 8'h01);
        commit();
        settle(10);
        chk13(chain_sum_out, 13'h110, "offset added");
        chk13(side_score_out, 13'h000, "side without offset");
        u_host.ctrl_write(bcc_pkg::ADDR_OFFSET_LO, 8'h20);
        latency(n0);
        u_host.ctrl_write(bcc_pkg::ADDR_DELAY, 8'h05);
        u_host.ctrl_write(bcc_pkg::ADDR_OFFSET_LO, 8'h30);
        latency(n5);
        chk13(13'(n5 - n0), 13'h005, "delay length");
        chk13(chain_sum_out, 13'h130, "offset after delay");
        $display("test offset delay done");
    endtask
    // eight-bit samples weight stage k by 2^k
    task automatic t_width8();
        u_host.ctrl_write(bcc_pkg::ADDR_OFFSET_LO, 8'h00);
        u_host.ctrl_write(bcc_pkg::ADDR_OFFSET_HI, 8'h00);
        load(8'h03, 8'h00, 8'h00);
        commit();
        data_in = 8'h0f;
        settle(60);
        chk13(chain_sum_out, 13'h1e00, "eight bit upper stages");
        u_host.ctrl_write(bcc_pkg::ADDR_CONFIG, 8'h10);
        repeat (32) u_host.ref_write(8'h00);
        load(8'h03, 8'h00, 8'hff);
        commit();
        data_in = 8'h05;
        settle(60);
        chk13(chain_sum_out, 13'h0a0, "eight bit ones reference");
        chk13(side_score_out, 13'h0a0, "eight bit side");
        $display("test width8 done");
    endtask
    // split correlators, 4x32 then 1x128 window
    task automatic t_split();
        u_host.ctrl_write(bcc_pkg::ADDR_CONFIG, 8'h04);
        commit();
        settle(60);
        chk13(chain_sum_out, 13'h040, "split main 4x32");
        chk13(side_score_out, 13'h000, "split side 4x32");
        u_host.ctrl_write(bcc_pkg::ADDR_CONFIG, 8'h0c);
        commit();
        settle(160);
        chk13(chain_sum_out, 13'h080, "split main 1x128");
        chk13(side_score_out, 13'h000, "split side 1x128");
        $display("test split done");
    endtask
    // two- and four-bit samples: stages chain per bit, weight by bit position
    task automatic t_width24();
        u_host.ctrl_write(bcc_pkg::ADDR_CONFIG, 8'h01);
        commit();
        data_in = 8'h02;
        settle(170);
        chk13(chain_sum_out, 13'h100, "two bit odd chain");
        chk13(side_score_out, 13'h100, "two bit side");
        u_host.ctrl_write(bcc_pkg::ADDR_CONFIG, 8'h02);
        commit();
        data_in = 8'h0c;
        settle(100);
        chk13(chain_sum_out, 13'h300, "four bit upper chains");
        $display("test width24 done");
    endtask
    // main sequence
    initial begin
        rst = 1'b1;
        data_in = 8'h00;
        commit_strobe_n = 1'b1;
        chain_sum_in = 13'h000;
        settle(3);
        rst = 1'b0;
        chk13(chain_sum_out, 13'h000, "reset cascade");
        chk13(side_score_out, 13'h000, "reset side");
        t_plain();
        t_mask();
        t_offset_delay();
        t_width8();
        t_split();
        t_width24();
        stop_test();
    end
endmodule
